// >>> rtl/vsr_regs.sv
// axi4-lite register bank for video status, payload identification and insertion control
// Contract
// - read-only 5-bit detected standard, bits 14:10
// - bit 9 low progressive, high interlaced
// - bit 8 high when fully locked
// - read-only active words per line, bits 11:0
// - read-only total words per line, bits 12:0
// - read-only total lines per frame, bits 10:0
// - read-only active lines per field, bits 10:0
// - writable field one payload line, bits 10:0
// - writable field two payload line, bits 10:0
// - read-only timing format error flag, bit 15
// - vertical timing shift field, bits 8:6
// - horizontal timing shift field, bits 5:3
// - bit 0 inverts detected field polarity
// - bit 15 selects separate or concatenated mode
// - read-only dropped packet flag, bit 14
// - read-only ram collision flag, bit 13
// - bits 10:0 give first or only line
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module vsr_regs
  import vsr_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [4:0] detected_standard_code_i,
  input wire logic scan_type_flag_i,
  input wire logic standard_locked_i,
  input wire logic [11:0] active_words_count_i,
  input wire logic [12:0] total_words_count_i,
  input wire logic [10:0] frame_lines_count_i,
  input wire logic [10:0] field_active_lines_count_i,
  input wire logic timing_format_error_i,
  input wire logic aux_packet_dropped_i,
  input wire logic ram_access_collision_i,
  input wire logic field_i,
  output logic [15:0] payload_bytes_one_two_o,
  output logic [15:0] payload_bytes_three_four_o,
  output logic [10:0] payload_line_first_field_o,
  output logic [10:0] payload_line_second_field_o,
  output logic [2:0] vertical_timing_shift_o,
  output logic [2:0] horizontal_timing_shift_o,
  output logic field_polarity_flip_o,
  output logic field_o,
  output logic aux_insert_mode_o,
  output logic [10:0] aux_first_line_o
);

  // mapped means a documented index, a word-aligned address and nothing above the index bits
  function automatic logic vsr_is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[VSR_IDX_MSB:VSR_IDX_LSB];
    vsr_is_mapped = (a[ADDR_W-1:VSR_IDX_MSB+1] == '0) && (a[1:0] == 2'h0) &&
      (idx == VSR_IDX_STD_STATUS || idx == VSR_IDX_PAYLOAD_A || idx == VSR_IDX_PAYLOAD_B ||
       idx == VSR_IDX_ACT_WORDS || idx == VSR_IDX_TOT_WORDS || idx == VSR_IDX_FRAME_LINES ||
       idx == VSR_IDX_FIELD_LINES || idx == VSR_IDX_LINE_F1 || idx == VSR_IDX_LINE_F2 ||
       idx == VSR_IDX_TIMING_CTRL || idx == VSR_IDX_AUX_CTRL);
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] vsr_merge16(input logic [15:0] old, input logic [31:0] d,
                                              input logic [3:0] strb);
    vsr_merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction

  // captured status
  logic [4:0] std_q;
  logic scan_q;
  logic lock_q;
  logic [11:0] act_words_q;
  logic [12:0] tot_words_q;
  logic [10:0] frame_lines_q;
  logic [10:0] field_lines_q;
  logic fmt_err_q;
  logic drop_q;
  logic coll_q;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      std_q <= 5'h00;
      scan_q <= 1'b0;
      lock_q <= 1'b0;
      act_words_q <= 12'h000;
      tot_words_q <= 13'h0000;
      frame_lines_q <= 11'h000;
      field_lines_q <= 11'h000;
      fmt_err_q <= 1'b0;
      drop_q <= 1'b0;
      coll_q <= 1'b0;
    end else begin
      std_q <= detected_standard_code_i;
      scan_q <= scan_type_flag_i;
      lock_q <= standard_locked_i;
      act_words_q <= active_words_count_i;
      tot_words_q <= total_words_count_i;
      frame_lines_q <= frame_lines_count_i;
      field_lines_q <= field_active_lines_count_i;
      fmt_err_q <= timing_format_error_i;
      drop_q <= aux_packet_dropped_i;
      coll_q <= ram_access_collision_i;
    end
  end

  // write channel
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic write_fire;
  logic aw_hs;
  logic w_hs;
  logic aw_have_d;
  logic w_have_d;
  logic bvalid_d;
  logic [7:0] w_idx;

  assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
  assign w_hs = s_axi_wvalid_i && s_axi_wready_o;
  assign write_fire = aw_have_q && w_have_q && !s_axi_bvalid_o;
  assign aw_have_d = write_fire ? 1'b0 : (aw_have_q || aw_hs);
  assign w_have_d = write_fire ? 1'b0 : (w_have_q || w_hs);
  assign bvalid_d = write_fire ? 1'b1 : (s_axi_bvalid_o && !s_axi_bready_i);
  assign w_idx = aw_addr_q[VSR_IDX_MSB:VSR_IDX_LSB];

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= VSR_RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      s_axi_awready_o <= !aw_have_d && !bvalid_d;
      s_axi_wready_o <= !w_have_d && !bvalid_d;
      s_axi_bvalid_o <= bvalid_d;
      if (aw_hs) begin
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (w_hs) begin
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
      if (write_fire) begin
        s_axi_bresp_o <= vsr_is_mapped(aw_addr_q) ? VSR_RESP_OKAY : VSR_RESP_SLVERR;
      end
    end
  end

  // writable registers; read-only indices fall through untouched
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      payload_bytes_one_two_o <= VSR_RST_REG16;
      payload_bytes_three_four_o <= VSR_RST_REG16;
      payload_line_first_field_o <= VSR_RST_LINE;
      payload_line_second_field_o <= VSR_RST_LINE;
      vertical_timing_shift_o <= VSR_RST_SHIFT;
      horizontal_timing_shift_o <= VSR_RST_SHIFT;
      field_polarity_flip_o <= 1'b0;
      aux_insert_mode_o <= 1'b0;
      aux_first_line_o <= VSR_RST_LINE;
    end else if (write_fire && vsr_is_mapped(aw_addr_q)) begin
      unique case (w_idx)
        VSR_IDX_PAYLOAD_A: begin
          payload_bytes_one_two_o <= vsr_merge16(payload_bytes_one_two_o, w_data_q, w_strb_q);
        end
        VSR_IDX_PAYLOAD_B: begin
          payload_bytes_three_four_o <= vsr_merge16(payload_bytes_three_four_o, w_data_q, w_strb_q);
        end
        VSR_IDX_LINE_F1: begin
          if (w_strb_q[1]) begin
            payload_line_first_field_o[10:8] <= w_data_q[VSR_LINE_MSB:8];
          end
          if (w_strb_q[0]) begin
            payload_line_first_field_o[7:0] <= w_data_q[7:0];
          end
        end
        VSR_IDX_LINE_F2: begin
          if (w_strb_q[1]) begin
            payload_line_second_field_o[10:8] <= w_data_q[VSR_LINE_MSB:8];
          end
          if (w_strb_q[0]) begin
            payload_line_second_field_o[7:0] <= w_data_q[7:0];
          end
        end
        VSR_IDX_TIMING_CTRL: begin
          if (w_strb_q[1]) begin
            vertical_timing_shift_o[2] <= w_data_q[VSR_VSHIFT_MSB];
          end
          if (w_strb_q[0]) begin
            vertical_timing_shift_o[1:0] <= w_data_q[VSR_VSHIFT_MSB-1:VSR_VSHIFT_LSB];
            horizontal_timing_shift_o <= w_data_q[VSR_HSHIFT_MSB:VSR_HSHIFT_LSB];
            field_polarity_flip_o <= w_data_q[VSR_FLIP_BIT];
          end
        end
        VSR_IDX_AUX_CTRL: begin
          if (w_strb_q[1]) begin
            aux_insert_mode_o <= w_data_q[VSR_MODE_BIT];
            aux_first_line_o[10:8] <= w_data_q[VSR_LINE_MSB:8];
          end
          if (w_strb_q[0]) begin
            aux_first_line_o[7:0] <= w_data_q[7:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // field indication with optional inversion
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      field_o <= 1'b0;
    end else begin
      field_o <= field_i ^ field_polarity_flip_o;
    end
  end

  // read channel
  logic ar_hs;
  logic rvalid_d;
  logic [7:0] r_idx;
  logic [15:0] r_word;

  assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
  assign rvalid_d = ar_hs ? 1'b1 : (s_axi_rvalid_o && !s_axi_rready_i);
  assign r_idx = s_axi_araddr_i[VSR_IDX_MSB:VSR_IDX_LSB];

  always_comb begin
    r_word = 16'h0000;
    unique case (r_idx)
      VSR_IDX_STD_STATUS: r_word = {1'b0, std_q, scan_q, lock_q, 8'h00};
      VSR_IDX_PAYLOAD_A: r_word = payload_bytes_one_two_o;
      VSR_IDX_PAYLOAD_B: r_word = payload_bytes_three_four_o;
      VSR_IDX_ACT_WORDS: r_word = {4'h0, act_words_q};
      VSR_IDX_TOT_WORDS: r_word = {3'h0, tot_words_q};
      VSR_IDX_FRAME_LINES: r_word = {5'h00, frame_lines_q};
      VSR_IDX_FIELD_LINES: r_word = {5'h00, field_lines_q};
      VSR_IDX_LINE_F1: r_word = {5'h00, payload_line_first_field_o};
      VSR_IDX_LINE_F2: r_word = {5'h00, payload_line_second_field_o};
      VSR_IDX_TIMING_CTRL: r_word = {fmt_err_q, 6'h00, vertical_timing_shift_o,
                                     horizontal_timing_shift_o, 2'h0, field_polarity_flip_o};
      VSR_IDX_AUX_CTRL: r_word = {aux_insert_mode_o, drop_q, coll_q, 2'h0, aux_first_line_o};
      default: r_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= VSR_RESP_OKAY;
    end else begin
      s_axi_arready_o <= !rvalid_d;
      s_axi_rvalid_o <= rvalid_d;
      if (ar_hs) begin
        s_axi_rdata_o <= vsr_is_mapped(s_axi_araddr_i) ? {16'h0000, r_word} : 32'h0000_0000;
        s_axi_rresp_o <= vsr_is_mapped(s_axi_araddr_i) ? VSR_RESP_OKAY : VSR_RESP_SLVERR;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_read_of(logic [7:0] idx);
    ar_hs && vsr_is_mapped(s_axi_araddr_i) && (r_idx == idx);
  endsequence

  sequence s_write_of(logic [7:0] idx);
    write_fire && vsr_is_mapped(aw_addr_q) && (w_idx == idx) && (w_strb_q == 4'hf);
  endsequence

  property p_std_code;
    s_read_of(VSR_IDX_STD_STATUS) |=> s_axi_rvalid_o &&
      (s_axi_rdata_o[VSR_STD_MSB:VSR_STD_LSB] == $past(detected_standard_code_i, 2));
  endproperty
  a_std_code: assert property (p_std_code) else $error("standard code readback wrong");

  property p_scan_lock;
    s_read_of(VSR_IDX_STD_STATUS) |=> (s_axi_rdata_o[VSR_SCAN_BIT] == $past(scan_type_flag_i, 2)) &&
      (s_axi_rdata_o[VSR_LOCK_BIT] == $past(standard_locked_i, 2)) && (s_axi_rdata_o[7:0] == 8'h00);
  endproperty
  a_scan_lock: assert property (p_scan_lock) else $error("scan or lock bit readback wrong");

  property p_lock_bit;
    s_read_of(VSR_IDX_STD_STATUS) ##1 s_axi_rdata_o[VSR_LOCK_BIT] |-> $past(standard_locked_i, 2);
  endproperty
  a_lock_bit: assert property (p_lock_bit) else $error("lock bit set without lock");

  property p_active_words;
    s_read_of(VSR_IDX_ACT_WORDS) |=> s_axi_rdata_o == {20'h00000, $past(active_words_count_i, 2)};
  endproperty
  a_active_words: assert property (p_active_words) else $error("active words readback wrong");

  property p_total_words;
    s_read_of(VSR_IDX_TOT_WORDS) |=> s_axi_rdata_o == {19'h00000, $past(total_words_count_i, 2)};
  endproperty
  a_total_words: assert property (p_total_words) else $error("total words readback wrong");

  property p_line_f1;
    s_write_of(VSR_IDX_LINE_F1) |=> payload_line_first_field_o == $past(w_data_q[VSR_LINE_MSB:0]);
  endproperty
  a_line_f1: assert property (p_line_f1) else $error("field one line not stored");

  property p_field_flip;
    !sys_rst_i |=> field_o == ($past(field_i) ^ $past(field_polarity_flip_o));
  endproperty
  a_field_flip: assert property (p_field_flip) else $error("field polarity wrong");

  property p_mode_read;
    s_read_of(VSR_IDX_AUX_CTRL) ##1 (aux_insert_mode_o == $past(aux_insert_mode_o))
      |-> s_axi_rdata_o[VSR_MODE_BIT] == aux_insert_mode_o;
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("insert mode readback wrong");

  property p_ro_write;
    s_write_of(VSR_IDX_STD_STATUS) |=> $stable(payload_bytes_one_two_o) && $stable(aux_insert_mode_o) &&
      $stable(aux_first_line_o) && $stable(field_polarity_flip_o);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write changed state");

  property p_bresp;
    aw_hs ##[0:4] (aw_have_q && w_have_q) |-> ##[0:1] s_axi_bvalid_o;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response late");

endmodule // vsr_regs

// >>> rtl/vsr_pkg.sv
// register indices, field positions, reset values and bus codes of the video status register bank
package vsr_pkg;
  localparam int unsigned VSR_DATA_W = 32;
  localparam int unsigned VSR_REG_W = 16;
  localparam int unsigned VSR_IDX_LSB = 2;
  localparam int unsigned VSR_IDX_MSB = 9;

  localparam logic [7:0] VSR_IDX_STD_STATUS = 8'h04;
  localparam logic [7:0] VSR_IDX_PAYLOAD_A = 8'h0a;
  localparam logic [7:0] VSR_IDX_PAYLOAD_B = 8'h0b;
  localparam logic [7:0] VSR_IDX_ACT_WORDS = 8'h0e;
  localparam logic [7:0] VSR_IDX_TOT_WORDS = 8'h0f;
  localparam logic [7:0] VSR_IDX_FRAME_LINES = 8'h10;
  localparam logic [7:0] VSR_IDX_FIELD_LINES = 8'h11;
  localparam logic [7:0] VSR_IDX_LINE_F1 = 8'h1b;
  localparam logic [7:0] VSR_IDX_LINE_F2 = 8'h1c;
  localparam logic [7:0] VSR_IDX_TIMING_CTRL = 8'h1f;
  localparam logic [7:0] VSR_IDX_AUX_CTRL = 8'h20;

  localparam int unsigned VSR_STD_LSB = 10;
  localparam int unsigned VSR_STD_MSB = 14;
  localparam int unsigned VSR_SCAN_BIT = 9;
  localparam int unsigned VSR_LOCK_BIT = 8;
  localparam int unsigned VSR_FMT_ERR_BIT = 15;
  localparam int unsigned VSR_VSHIFT_LSB = 6;
  localparam int unsigned VSR_VSHIFT_MSB = 8;
  localparam int unsigned VSR_HSHIFT_LSB = 3;
  localparam int unsigned VSR_HSHIFT_MSB = 5;
  localparam int unsigned VSR_FLIP_BIT = 0;
  localparam int unsigned VSR_MODE_BIT = 15;
  localparam int unsigned VSR_DROP_BIT = 14;
  localparam int unsigned VSR_COLL_BIT = 13;
  localparam int unsigned VSR_LINE_MSB = 10;

  localparam logic [15:0] VSR_RST_REG16 = 16'h0000;
  localparam logic [10:0] VSR_RST_LINE = 11'h000;
  localparam logic [2:0] VSR_RST_SHIFT = 3'h0;

  localparam logic [1:0] VSR_RESP_OKAY = 2'h0;
  localparam logic [1:0] VSR_RESP_SLVERR = 2'h2;
endpackage

// >>> tb/vsr_regs_tb.sv
// self-checking bench for the video status register bank
`timescale 1ns/10ps
module vsr_regs_tb;
  import vsr_pkg::*;
  typedef struct packed {
    logic [7:0] idx;
    logic [31:0] wd;
    logic [3:0] strb;
    logic [15:0] rd;
  } vsr_row_t;
  localparam vsr_row_t ROWS [11] = '{
    '{VSR_IDX_STD_STATUS, 32'hffff_ffff, 4'hf, 16'h5700},
    '{VSR_IDX_PAYLOAD_A, 32'hdead_1234, 4'hf, 16'h1234},
    '{VSR_IDX_PAYLOAD_B, 32'h0000_a55a, 4'h1, 16'h005a},
    '{VSR_IDX_ACT_WORDS, 32'h0000_ffff, 4'hf, 16'h0abc},
    '{VSR_IDX_TOT_WORDS, 32'h0000_ffff, 4'hf, 16'h1bcd},
    '{VSR_IDX_FRAME_LINES, 32'h0000_ffff, 4'hf, 16'h05a5},
    '{VSR_IDX_FIELD_LINES, 32'h0000_ffff, 4'hf, 16'h02c3},
    '{VSR_IDX_LINE_F1, 32'h0000_ffff, 4'hf, 16'h07ff},
    '{VSR_IDX_LINE_F2, 32'h0000_0123, 4'hf, 16'h0123},
    '{VSR_IDX_TIMING_CTRL, 32'h0000_7ea9, 4'hf, 16'h80a9},
    '{VSR_IDX_AUX_CTRL, 32'h0000_7d55, 4'hf, 16'h4555}
  };
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
  logic [2:0] s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [31:0] s_axi_wdata_i = 32'h0000_0000;
  logic [3:0] s_axi_wstrb_i = 4'h0;
  logic [4:0] detected_standard_code_i = 5'h00;
  logic scan_type_flag_i = 1'b0, standard_locked_i = 1'b0, timing_format_error_i = 1'b0;
  logic aux_packet_dropped_i = 1'b0, ram_access_collision_i = 1'b0, field_i = 1'b0;
  logic [11:0] active_words_count_i = 12'h000;
  logic [12:0] total_words_count_i = 13'h0000;
  logic [10:0] frame_lines_count_i = 11'h000, field_active_lines_count_i = 11'h000;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [15:0] payload_bytes_one_two_o, payload_bytes_three_four_o;
  logic [10:0] payload_line_first_field_o, payload_line_second_field_o, aux_first_line_o;
  logic [2:0] vertical_timing_shift_o, horizontal_timing_shift_o;
  logic field_polarity_flip_o, field_o, aux_insert_mode_o;
  int bad_count = 0;
  int n_compared = 0;

  vsr_regs #(.ADDR_W(12)) u_dut (
    .clk_sys_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awprot_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arprot_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .detected_standard_code_i,
    .scan_type_flag_i, .standard_locked_i, .active_words_count_i, .total_words_count_i,
    .frame_lines_count_i, .field_active_lines_count_i, .timing_format_error_i, .aux_packet_dropped_i,
    .ram_access_collision_i, .field_i, .payload_bytes_one_two_o, .payload_bytes_three_four_o,
    .payload_line_first_field_o, .payload_line_second_field_o, .vertical_timing_shift_o,
    .horizontal_timing_shift_o, .field_polarity_flip_o, .field_o, .aux_insert_mode_o, .aux_first_line_o
  );

  always #10 clk_sys_i = ~clk_sys_i;

  task automatic give_verdict();
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  task automatic hang(input string name);
    $display("[FAIL] %s expected answer seen none", name);
    bad_count++;
    give_verdict();
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys_i);
      if (s_axi_awvalid_i && s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o === 1'b1) break;
    end
    s_axi_bready_i <= 1'b0;
    if (n == 40) hang("write response");
    chk($sformatf("bresp %h", a), 32'(s_axi_bresp_o), 32'(er));
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [15:0] ed, input logic [1:0] er);
    int n;
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys_i);
      if (s_axi_arvalid_i && s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o === 1'b1) break;
    end
    s_axi_rready_i <= 1'b0;
    if (n == 40) hang("read response");
    chk($sformatf("rdata %h", a), s_axi_rdata_o, {16'h0000, ed});
    chk($sformatf("rresp %h", a), 32'(s_axi_rresp_o), 32'(er));
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    foreach (ROWS[i]) axi_rd({2'b00, ROWS[i].idx, 2'b00}, 16'h0000, VSR_RESP_OKAY);
    detected_standard_code_i <= 5'h15;
    scan_type_flag_i <= 1'b1;
    standard_locked_i <= 1'b1;
    active_words_count_i <= 12'habc;
    total_words_count_i <= 13'h1bcd;
    frame_lines_count_i <= 11'h5a5;
    field_active_lines_count_i <= 11'h2c3;
    timing_format_error_i <= 1'b1;
    aux_packet_dropped_i <= 1'b1;
    foreach (ROWS[i]) begin
      axi_wr({2'b00, ROWS[i].idx, 2'b00}, ROWS[i].wd, ROWS[i].strb, VSR_RESP_OKAY);
      axi_rd({2'b00, ROWS[i].idx, 2'b00}, ROWS[i].rd, VSR_RESP_OKAY);
    end
    chk("payload a", 32'(payload_bytes_one_two_o), 32'h1234);
    chk("payload b", 32'(payload_bytes_three_four_o), 32'h005a);
    chk("line f1", 32'(payload_line_first_field_o), 32'h07ff);
    chk("line f2", 32'(payload_line_second_field_o), 32'h0123);
    chk("vshift", 32'(vertical_timing_shift_o), 32'h2);
    chk("hshift", 32'(horizontal_timing_shift_o), 32'h5);
    chk("flip", 32'(field_polarity_flip_o), 32'h1);
    chk("aux mode", 32'(aux_insert_mode_o), 32'h0);
    chk("aux line", 32'(aux_first_line_o), 32'h0555);
    // unmapped, misaligned and out-of-range addresses
    axi_wr(12'h014, 32'h0000_ffff, 4'hf, VSR_RESP_SLVERR);
    axi_rd(12'h014, 16'h0000, VSR_RESP_SLVERR);
    axi_wr(12'h029, 32'h0000_ffff, 4'hf, VSR_RESP_SLVERR);
    axi_wr(12'h428, 32'h0000_ffff, 4'hf, VSR_RESP_SLVERR);
    axi_rd(12'h028, 16'h1234, VSR_RESP_OKAY);
    // field polarity, live status flags
    field_i <= 1'b1;
    timing_format_error_i <= 1'b0;
    standard_locked_i <= 1'b0;
    scan_type_flag_i <= 1'b0;
    detected_standard_code_i <= 5'h0a;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("field inverted", 32'(field_o), 32'h0);
    axi_rd(12'h010, 16'h2800, VSR_RESP_OKAY);
    axi_wr(12'h07c, 32'h0000_01b8, 4'hf, VSR_RESP_OKAY);
    axi_rd(12'h07c, 16'h01b8, VSR_RESP_OKAY);
    aux_packet_dropped_i <= 1'b0;
    ram_access_collision_i <= 1'b1;
    @(negedge clk_sys_i);
    chk("field direct", 32'(field_o), 32'h1);
    chk("vshift 6", 32'(vertical_timing_shift_o), 32'h6);
    // concatenated mode with collision flag
    axi_wr(12'h080, 32'h0000_8000, 4'hf, VSR_RESP_OKAY);
    axi_rd(12'h080, 16'ha000, VSR_RESP_OKAY);
    @(negedge clk_sys_i);
    chk("aux mode 1", 32'(aux_insert_mode_o), 32'h1);
    chk("aux line 0", 32'(aux_first_line_o), 32'h0000);
    // second reset in mid-run
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("awready in reset", 32'(s_axi_awready_o), 32'h0);
    chk("payload a reset", 32'(payload_bytes_one_two_o), 32'h0000);
    chk("aux mode reset", 32'(aux_insert_mode_o), 32'h0);
    axi_rd(12'h06c, 16'h0000, VSR_RESP_OKAY);
    give_verdict();
  end
endmodule // vsr_regs_tb
